// ### hw/scp_top.sv
`timescale 1ns/1ns
module scp_top
  import scp_pkg::*;
#(
  parameter int REG_DEPTH = 16
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial port pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Register write events, system clock domain
  output logic reg_wr_o,
  output logic [14:0] reg_addr_o,
  output logic [7:0] reg_data_o,
  // Applied tuning word, system clock domain
  output logic [47:0] tuning_word_o,
  output logic tuning_word_upd_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] rev4(input logic [3:0] n);
    return {n[0], n[1], n[2], n[3]};
  endfunction

  function automatic logic [2:0] bit_sel(input logic lsb,
                                          input logic [2:0] cnt);
    return lsb ? cnt : (BYTE_LAST - cnt);
  endfunction

  function automatic logic both_set(input logic [7:0] c, input int hi,
                                    input int lo);
    return c[hi] & c[lo];
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  scp_if bus ();

  logic link_rst;
  scp_state_t state;
  logic [3:0] icnt;
  logic [2:0] dcnt;
  logic [15:0] ish;
  logic [7:0] dsh;
  logic rw;
  logic [14:0] cur_addr;
  logic [15:0] next_ish;
  logic [7:0] next_dsh;
  logic [3:0] first_nib;
  logic [7:0] next_wdata;
  logic lsb_first;
  logic four_wire;
  logic step_up;
  logic byte_done;
  logic tx_bit;
  logic sdio_oe;
  logic sdo_oe;
  logic ev_tgl;
  logic [14:0] ev_addr;
  logic [7:0] ev_data;
  logic [2:0] ev_sync;
  logic [2:0] ftw_sync;
  logic wr_q;
  logic [14:0] addr_q;
  logic [7:0] data_q;
  logic [47:0] ftw_q;
  logic upd_q;

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  assign lsb_first = both_set(bus.cfg, CFG_LSB_HI, CFG_LSB_LO);
  assign four_wire = both_set(bus.cfg, CFG_SDO_HI, CFG_SDO_LO);
  assign step_up = both_set(bus.cfg, CFG_INC_HI, CFG_INC_LO);

  // Chip select high holds the whole link side idle, so a new select
  // always starts from the instruction phase.
  assign link_rst = cs_n_i | rst_i;

  // ---------------------------------------------------------------
  // Serial shifting
  // ---------------------------------------------------------------
  // The LSB-first shift places the first bit at bit 0, so both orders
  // leave the flag at bit 15 and the address below it.
  always_comb begin
    if (lsb_first) begin
      next_ish = {sdio_i, ish[15:1]};
      next_dsh = {sdio_i, dsh[7:1]};
    end else begin
      next_ish = {ish[14:0], sdio_i};
      next_dsh = {dsh[6:0], sdio_i};
    end
  end

  // Only the first nibble of a configuration write counts; the second is
  // rebuilt as its mirror so the copies never disagree.
  always_comb begin
    first_nib = lsb_first ? rev4(next_dsh[3:0]) : next_dsh[7:4];
    if (cur_addr == CFG_ADDR) begin
      next_wdata = {first_nib, rev4(first_nib)};
    end else begin
      next_wdata = next_dsh;
    end
  end

  assign byte_done = (state == SCP_ST_DATA) && (dcnt == BYTE_LAST);

  // ---------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      state <= SCP_ST_INSTR;
      icnt <= 4'h0;
      dcnt <= 3'h0;
      ish <= 16'h0000;
      dsh <= 8'h00;
      rw <= 1'b0;
      cur_addr <= 15'h0000;
    end else begin
      case (state)
        SCP_ST_INSTR: begin
          ish <= next_ish;
          icnt <= icnt + 4'h1;
          if (icnt == INSTR_LAST) begin
            rw <= next_ish[15];
            cur_addr <= next_ish[14:0];
            dcnt <= 3'h0;
            state <= SCP_ST_DATA;
          end
        end
        SCP_ST_DATA: begin
          dsh <= next_dsh;
          dcnt <= dcnt + 3'h1;
          if (dcnt == BYTE_LAST) begin
            if (step_up) begin
              cur_addr <= cur_addr + 15'h0001;
            end else begin
              cur_addr <= cur_addr - 15'h0001;
            end
          end
        end
        default: begin
          state <= SCP_ST_INSTR;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register access
  // ---------------------------------------------------------------
  // The write lands on the same edge that samples the final bit.
  assign bus.wr_stb = byte_done && !rw;
  assign bus.addr = cur_addr;
  assign bus.wdata = next_wdata;

  scp_regs #(
    .REG_DEPTH(REG_DEPTH)
  ) u_regs (
    .sclk_i(sclk_i),
    .rst_i(rst_i),
    .bus(bus)
  );

  // ---------------------------------------------------------------
  // Read data launch
  // ---------------------------------------------------------------
  // Falling-edge launch gives the controller half a clock of setup
  // before it samples on the next rising edge.
  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      tx_bit <= 1'b0;
      sdio_oe <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      tx_bit <= bus.rdata[bit_sel(lsb_first, dcnt)];
      sdio_oe <= (state == SCP_ST_DATA) && rw && !four_wire;
      sdo_oe <= (state == SCP_ST_DATA) && rw && four_wire;
    end
  end

  assign sdio_o = tx_bit;
  assign sdio_oe_o = sdio_oe;
  assign sdo_o = tx_bit;
  assign sdo_oe_o = sdo_oe;

  // ---------------------------------------------------------------
  // Write event capture, link side
  // ---------------------------------------------------------------
  // Address and data stay put for at least eight serial clocks, far
  // longer than the toggle needs to cross.
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ev_tgl <= 1'b0;
      ev_addr <= 15'h0000;
      ev_data <= 8'h00;
    end else if (bus.wr_stb) begin
      ev_tgl <= ~ev_tgl;
      ev_addr <= cur_addr;
      ev_data <= next_wdata;
    end
  end

  // ---------------------------------------------------------------
  // System clock side
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_sync <= 3'h0;
      ftw_sync <= 3'h0;
    end else begin
      ev_sync <= {ev_sync[1:0], ev_tgl};
      ftw_sync <= {ftw_sync[1:0], bus.ftw_tgl};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      addr_q <= 15'h0000;
      data_q <= 8'h00;
    end else begin
      wr_q <= ev_sync[2] ^ ev_sync[1];
      if (ev_sync[2] ^ ev_sync[1]) begin
        addr_q <= ev_addr;
        data_q <= ev_data;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      upd_q <= 1'b0;
      ftw_q <= 48'h0000_0000_0000;
    end else begin
      upd_q <= ftw_sync[2] ^ ftw_sync[1];
      if (ftw_sync[2] ^ ftw_sync[1]) begin
        ftw_q <= bus.frequency_tuning_word;
      end
    end
  end

  assign reg_wr_o = wr_q;
  assign reg_addr_o = addr_q;
  assign reg_data_o = data_q;
  assign tuning_word_o = ftw_q;
  assign tuning_word_upd_o = upd_q;
endmodule // scp_top

// ### inc/scp_pkg.sv
// How it works
// - Select falling starts a cycle; transfers only while select is low.
// - The shared data pin is released whenever chip select is high.
// - Both output-enable copies set selects 4-wire mode, separate read pin.
// - Mirrored bit-order field picks the order; zero at reset is MSB first.
// - MSB first: direction flag, address 14 to 0, then data 7 to 0.
// - LSB first: address 0 to 14, direction flag, then data 0 to 7.
// - First byte hits the instruction address; each further byte the next.
// - Address steps up per byte when the direction field is 1, else down.
// - Select high then low aborts and restarts the instruction phase.
// - Configuration register writes use only the first nibble received.
// - That first-nibble handling is the same in either bit order.
// - Instruction is the first 16 rising clocks: flag, 15-bit address.
// - Direction flag 1 requests a read, 0 requests a write.
// - Input samples on rising edges; read data launches on falling edges.
// - Registers update on a byte's last bit; tuning words wait for a load.
package scp_pkg;
  // ---------------------------------------------------------------
  // Widths and counts
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [14:0] CFG_ADDR = 15'h0000;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [14:0] FTW_LOAD_ADDR = 15'h0008;
  localparam logic [14:0] FTW_BASE = 15'h000A;
  localparam int FTW_BYTES = 6;
  localparam int FTW_LOAD_BIT = 0;
  // Configuration register fields, upper copy and mirrored copy.
  localparam int CFG_SRST_HI = 7;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_INC_HI = 5;
  localparam int CFG_SDO_HI = 4;
  localparam int CFG_SDO_LO = 3;
  localparam int CFG_INC_LO = 2;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_SRST_LO = 0;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic {
    SCP_ST_INSTR,
    SCP_ST_DATA
  } scp_state_t;
endpackage

// ### inc/scp_if.sv
`timescale 1ns/1ns
interface scp_if;
  logic wr_stb;
  logic [14:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] cfg;
  logic [47:0] frequency_tuning_word;
  logic ftw_tgl;
  modport port (output wr_stb, addr, wdata,
                input rdata, cfg, frequency_tuning_word, ftw_tgl);
  modport regs (input wr_stb, addr, wdata,
                output rdata, cfg, frequency_tuning_word, ftw_tgl);
endinterface

// ### hw/scp_regs.sv
`timescale 1ns/1ns
module scp_regs
  import scp_pkg::*;
#(
  parameter int REG_DEPTH = 16
) (
  // Link clock and reset
  input wire logic sclk_i,
  input wire logic rst_i,
  // Register access
  scp_if.regs bus
);
  localparam int IW = $clog2(REG_DEPTH);

  logic [7:0] mem [REG_DEPTH];
  logic [47:0] ftw_live;
  logic ftw_tgl;
  logic in_range;
  logic [IW-1:0] idx;
  logic load_hit;

  assign in_range = ({17'h0_0000, bus.addr} < 32'(REG_DEPTH));
  assign idx = bus.addr[IW-1:0];
  assign load_hit = bus.wr_stb && (bus.addr == FTW_LOAD_ADDR) &&
                    bus.wdata[FTW_LOAD_BIT];

  // ---------------------------------------------------------------
  // Register array
  // ---------------------------------------------------------------
  // A soft reset write returns every register to its default, itself too.
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        mem[i] <= REG_RESET;
      end
      mem[0] <= CFG_RESET;
    end else if (bus.wr_stb && in_range) begin
      if (bus.addr == CFG_ADDR && bus.wdata[CFG_SRST_HI]) begin
        for (int i = 0; i < REG_DEPTH; i++) begin
          mem[i] <= REG_RESET;
        end
        mem[0] <= CFG_RESET;
      end else if (bus.addr == FTW_LOAD_ADDR) begin
        mem[idx] <= bus.wdata & ~(8'h01 << FTW_LOAD_BIT);
      end else begin
        mem[idx] <= bus.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Tuning word, applied only on load request
  // ---------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      ftw_live <= 48'h0000_0000_0000;
      ftw_tgl <= 1'b0;
    end else if (load_hit) begin
      for (int i = 0; i < FTW_BYTES; i++) begin
        ftw_live[i*8 +: 8] <= mem[int'(FTW_BASE) + i];
      end
      ftw_tgl <= ~ftw_tgl;
    end
  end

  assign bus.rdata = in_range ? mem[idx] : 8'h00;
  assign bus.cfg = mem[0];
  assign bus.frequency_tuning_word = ftw_live;
  assign bus.ftw_tgl = ftw_tgl;
endmodule // scp_regs

// ### test/scp_top_props.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// Port checker
// --------------------------------------------------------------
module scp_top_props
  import scp_pkg::*;
#(
  parameter int REG_DEPTH = 16
) (
  // Clock, reset and serial pins
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe_o,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  // System side
  input wire logic reg_wr_o,
  input wire logic [14:0] reg_addr_o,
  input wire logic [7:0] reg_data_o,
  input wire logic [47:0] tuning_word_o,
  input wire logic tuning_word_upd_o
);
  // The pins are oversampled by the system clock, ten times faster than
  // the link clock, so one clock serves every check here.
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_idle_release: assert property (
    cs_n_i |-> !sdio_oe_o && !sdo_oe_o)
    else $error("data pin driven while deselected");
  chk_one_mode: assert property (!(sdio_oe_o && sdo_oe_o))
    else $error("both output pins driven");
  chk_oe_held: assert property (
    sdio_oe_o && !cs_n_i |=> sdio_oe_o || cs_n_i)
    else $error("shared pin released inside a read");
  chk_launch_fall: assert property (
    !cs_n_i && $changed(sdio_o) |-> !sclk_i)
    else $error("read bit changed while serial clock high");
  chk_same_bit: assert property (sdo_oe_o |-> sdo_o == sdio_o)
    else $error("separate output pin disagrees");
  chk_wr_pulse: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write event longer than one cycle");
  chk_event_held: assert property (
    $changed(reg_addr_o) || $changed(reg_data_o) |-> reg_wr_o)
    else $error("write event fields moved without a pulse");
  chk_load_pulse: assert property (
    tuning_word_upd_o |=> !tuning_word_upd_o)
    else $error("load pulse longer than one cycle");
  chk_word_held: assert property (
    $changed(tuning_word_o) |-> tuning_word_upd_o)
    else $error("tuning word moved without a load");
endmodule // scp_top_props

bind scp_top scp_top_props #(.REG_DEPTH(REG_DEPTH)) i_scp_top_props (
  .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
  .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .sdo_o(sdo_o),
  .sdo_oe_o(sdo_oe_o), .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o),
  .reg_data_o(reg_data_o), .tuning_word_o(tuning_word_o),
  .tuning_word_upd_o(tuning_word_upd_o));

// ### test/scp_host.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// Serial controller model
// --------------------------------------------------------------
module scp_host (
  // Serial pins toward the port
  output logic sclk_o,
  output logic cs_n_o,
  output logic sd_o,
  // Lines seen back from the port
  input wire logic sdio_i,
  input wire logic sdo_i
);
  // Select starts low and rises after reset does, so the port's link
  // logic sees one clean reset edge instead of a start-up race.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    sd_o = 1'b0;
    #2 cs_n_o = 1'b1;
  end
  // The clock stands still outside frames; a released data line
  // keeps toggling so a stale value can never look valid.
  task automatic xfer(input logic rw, input logic [14:0] a, input int n,
      input int cut, input logic lsb, input logic four,
      input logic [31:0] wd, output logic [31:0] rd);
    logic [15:0] ins;
    int k;
    int p;
    ins = {rw, a};
    rd = '0;
    #3 cs_n_o = 1'b0;
    for (k = 0; k < 16 + 8 * n; k++) begin
      if (cut != 0 && k == cut) break;
      p = 8 * ((k - 16) / 8) + (lsb ? (k - 16) % 8 : 7 - (k - 16) % 8);
      if (k < 16)
        sd_o = lsb ? ins[k] : ins[15 - k];
      else if (!rw) sd_o = wd[p];
      else sd_o = ~sd_o;
      #40 sclk_o = 1'b1;
      if (rw && k >= 16) rd[p] = four ? sdo_i : sdio_i;
      #40 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    sd_o = ~sd_o;
    #80;
  endtask
endmodule // scp_host

// ### test/tb.sv
`timescale 1ns/1ns
// --------------------------------------------------------------
// Testbench
// --------------------------------------------------------------
module tb;
  import scp_pkg::*;
  logic clk_i, rst_i, sclk, cs_n, sd, sdio_o, sdio_oe_o, sdo_o, sdo_oe_o;
  logic reg_wr_o, tuning_word_upd_o, saw3, saw4;
  logic [14:0] reg_addr_o;
  logic [7:0] reg_data_o;
  logic [47:0] tuning_word_o;
  logic [31:0] rd;
  logic [22:0] wq[$];
  int bad_count, compares, upd_seen;
  wire sdio_line = sdio_oe_o ? sdio_o : sd;
  scp_top #(.REG_DEPTH(16)) i_scp_top (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio_line), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .reg_wr_o(reg_wr_o), .reg_addr_o(reg_addr_o), .reg_data_o(reg_data_o),
    .tuning_word_o(tuning_word_o), .tuning_word_upd_o(tuning_word_upd_o));
  scp_host i_scp_host (.sclk_o(sclk), .cs_n_o(cs_n), .sd_o(sd),
    .sdio_i(sdio_line), .sdo_i(sdo_o));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // Outputs are taken at the falling edge, where they have settled.
  always @(negedge clk_i) begin
    if (reg_wr_o === 1'b1) wq.push_back({reg_addr_o, reg_data_o});
    if (tuning_word_upd_o === 1'b1) upd_seen++;
    if (sdio_oe_o === 1'b1) saw3 = 1'b1;
    if (sdo_oe_o === 1'b1) saw4 = 1'b1;
  end
  task automatic check(input string name, input logic [47:0] seen,
      input logic [47:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d,
      input logic lsb, input logic four);
    i_scp_host.xfer(1'b0, a, n, 0, lsb, four, d, rd);
  endtask
  task automatic rdf(input logic [14:0] a, input int n, input logic lsb,
      input logic four);
    i_scp_host.xfer(1'b1, a, n, 0, lsb, four, 32'h0000_0000, rd);
  endtask
  task automatic expect_wr(input logic [14:0] a, input logic [7:0] d);
    int i;
    for (i = 0; i < 300 && wq.size() == 0; i++) @(posedge clk_i);
    check("write event", wq.size() > 0 ? wq.pop_front() : 23'h7f_ffff, {a, d});
  endtask
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
  initial begin
    rst_i = 1'b0;
    saw3 = 1'b0;
    saw4 = 1'b0;
    #1 rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    rdf(CFG_ADDR, 1, 1'b0, 1'b0);
    check("cfg reset", rd[7:0], CFG_RESET);
    wr(15'h0001, 1, 32'h0000_0055, 1'b0, 1'b0);
    expect_wr(15'h0001, 8'h55);
    wr(15'h0005, 3, 32'h00C3_B2A1, 1'b0, 1'b0);
    expect_wr(15'h0005, 8'hA1);
    expect_wr(15'h0004, 8'hB2);
    expect_wr(15'h0003, 8'hC3);
    rdf(15'h0005, 3, 1'b0, 1'b0);
    check("read down", rd[23:0], 24'hC3_B2A1);
    check("shared pin drove", {saw3, saw4}, 2'b10);
    i_scp_host.xfer(1'b0, 15'h0002, 1, 20, 1'b0, 1'b0, 32'h0000_00FF, rd);
    check("partial byte", wq.size(), 0);
    rdf(15'h0002, 1, 1'b0, 1'b0);
    check("aborted reg", rd[7:0], 8'h00);
    wr(CFG_ADDR, 1, 32'h0000_003F, 1'b0, 1'b0);
    expect_wr(CFG_ADDR, 8'h3C);
    saw3 = 1'b0;
    wr(15'h0006, 2, 32'h0000_E2D1, 1'b0, 1'b1);
    expect_wr(15'h0006, 8'hD1);
    expect_wr(15'h0007, 8'hE2);
    rdf(15'h0006, 2, 1'b0, 1'b1);
    check("read up", rd[15:0], 16'hE2D1);
    check("output pin drove", {saw3, saw4}, 2'b01);
    wr(CFG_ADDR, 1, 32'h0000_006F, 1'b0, 1'b1);
    expect_wr(CFG_ADDR, 8'h66);
    wr(15'h0009, 1, 32'h0000_00C3, 1'b1, 1'b0);
    expect_wr(15'h0009, 8'hC3);
    rdf(15'h0009, 1, 1'b1, 1'b0);
    check("lsb read", rd[7:0], 8'hC3);
    wr(CFG_ADDR, 1, 32'h0000_00F0, 1'b1, 1'b0);
    expect_wr(CFG_ADDR, 8'h00);
    rdf(15'h0009, 1, 1'b0, 1'b0);
    check("msb again", rd[7:0], 8'hC3);
    wr(FTW_BASE, 1, 32'h0000_0012, 1'b0, 1'b0);
    expect_wr(FTW_BASE, 8'h12);
    check("word held", tuning_word_o, 48'h0);
    wr(FTW_LOAD_ADDR, 1, 32'h0000_0001, 1'b0, 1'b0);
    repeat (20) @(posedge clk_i);
    check("word applied", tuning_word_o, 48'h12);
    check("load pulses", upd_seen, 1);
    wq.delete();
    close_out();
  end
endmodule // tb
